// [verilog/motor_pwm_output_stage.sv]
// Motor PWM output stage: dead time, faults, overrides and duty registers
`timescale 1ns/1ps
module motor_pwm_output_stage (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [14:0] time_base_count,
  input  wire logic        period_start,
  input  wire logic        fault_a_n,
  input  wire logic        fault_b_n,
  output logic      [3:0]  pair_high_pin,
  output logic      [3:0]  pair_low_pin
);

  localparam int NP = motor_pwm_pkg::PAIRS;

  // Address match, used by every register write and by the read mux
  function automatic logic reg_match(input logic [7:0] addr, input logic [7:0] offset);
    reg_match = (addr == offset);
  endfunction : reg_match

  // Prescale tick: true once every 2^code cycles of the free counter
  function automatic logic prescale_tick(input logic [2:0] cnt, input logic [1:0] code);
    logic [2:0] mask;
    mask = 3'h0;
    case (code)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      2'h3: mask = 3'h7;
      default: mask = 3'h0;
    endcase
    prescale_tick = ((cnt & mask) == mask);
  endfunction : prescale_tick

  // Bus pipeline state
  logic        rd_pend_ff;    // Read waiting for its data cycle
  logic        wr_pend_ff;    // Write in its data phase
  logic [7:0]  addr_ff;       // Captured byte address of the transfer
  logic [31:0] hrdata_ff;     // Registered read data
  logic        hreadyout_ff;  // Registered ready
  logic        addr_hit;      // Address phase accepted this cycle

  // Software-visible registers
  logic [15:0] dead_cfg_ff;       // Dead-time prescales and counts
  logic [15:0] dead_sel_ff;       // Per-pair unit selects
  logic [15:0] fault_a_ctl_ff;    // Fault A control
  logic [15:0] fault_b_ctl_ff;    // Fault B control
  logic [15:0] override_ff;       // Override as written
  logic [15:0] override_act_ff;   // Override in force on the pins
  logic [15:0] update_ctl_ff;     // Pair modes and update controls
  logic [15:0] duty_buf_ff [NP];  // Duty values as written
  logic [15:0] duty_act_ff [NP];  // Duty values the comparators use

  // Fault state
  logic fault_a_latch_ff;  // Latched fault A
  logic fault_a_cbc_ff;    // Cycle-by-cycle fault A
  logic fault_b_latch_ff;  // Latched fault B
  logic fault_b_cbc_ff;    // Cycle-by-cycle fault B
  logic fault_a_on;        // Fault A override in force
  logic fault_b_on;        // Fault B override in force

  // Dead-time clocking and pair signals
  logic [2:0]  prescale_cnt_ff;  // Free-running prescale counter
  logic        tick_a;           // Unit A clock enable
  logic        tick_b;           // Unit B clock enable
  logic [NP-1:0] raw_pwm;        // Comparator outputs
  logic [NP-1:0] gen_high;       // Generator high drive after dead time
  logic [NP-1:0] gen_low;        // Generator low drive after dead time
  logic [NP-1:0] nxt_high_pin;   // Next high pin values
  logic [NP-1:0] nxt_low_pin;    // Next low pin values
  logic [NP-1:0] pin_high_ff;    // High pin flops
  logic [NP-1:0] pin_low_ff;     // Low pin flops

  // Typed views of the register words
  motor_pwm_pkg::dead_cfg_type     dead_cfg;
  motor_pwm_pkg::fault_ctl_type    fault_a_ctl;
  motor_pwm_pkg::fault_ctl_type    fault_b_ctl;
  motor_pwm_pkg::override_ctl_type override_act;

  assign dead_cfg     = motor_pwm_pkg::dead_cfg_type'(dead_cfg_ff);
  assign fault_a_ctl  = motor_pwm_pkg::fault_ctl_type'(fault_a_ctl_ff);
  assign fault_b_ctl  = motor_pwm_pkg::fault_ctl_type'(fault_b_ctl_ff);
  assign override_act = motor_pwm_pkg::override_ctl_type'(override_act_ff);

  // Only word transfers are issued, so hsize is not decoded
  assign addr_hit = hsel & hready & htrans[1];

  // Address phase capture; reads get one wait cycle so a write just
  // before them is already stored when the read mux is sampled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_ff   <= 1'b0;
      wr_pend_ff   <= 1'b0;
      addr_ff      <= 8'h00;
      hreadyout_ff <= 1'b1;
    end else begin
      rd_pend_ff   <= addr_hit & ~hwrite;
      wr_pend_ff   <= addr_hit & hwrite;
      hreadyout_ff <= ~(addr_hit & ~hwrite);
      if (addr_hit) begin
        addr_ff <= haddr[7:0];
      end
    end
  end

  // Read mux; unmapped words read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (rd_pend_ff) begin
      hrdata_ff <= 32'h0000_0000;
      if (reg_match(addr_ff, motor_pwm_pkg::ADDR_DEAD_TIME_CONFIG))
        hrdata_ff[15:0] <= dead_cfg_ff;
      if (reg_match(addr_ff, motor_pwm_pkg::ADDR_DEAD_TIME_SELECT))
        hrdata_ff[15:0] <= dead_sel_ff;
      if (reg_match(addr_ff, motor_pwm_pkg::ADDR_FAULT_A_CONTROL))
        hrdata_ff[15:0] <= fault_a_ctl_ff;
      if (reg_match(addr_ff, motor_pwm_pkg::ADDR_FAULT_B_CONTROL))
        hrdata_ff[15:0] <= fault_b_ctl_ff;
      if (reg_match(addr_ff, motor_pwm_pkg::ADDR_OVERRIDE_CONTROL))
        hrdata_ff[15:0] <= override_ff;
      if (reg_match(addr_ff, motor_pwm_pkg::ADDR_UPDATE_CONTROL))
        hrdata_ff[15:0] <= update_ctl_ff;
      if (reg_match(addr_ff, motor_pwm_pkg::ADDR_FAULT_STATUS)) begin
        hrdata_ff[motor_pwm_pkg::STAT_FAULT_A_BIT] <= fault_a_on;
        hrdata_ff[motor_pwm_pkg::STAT_FAULT_B_BIT] <= fault_b_on;
      end
      for (int i = 0; i < NP; i++) begin
        if (reg_match(addr_ff, motor_pwm_pkg::ADDR_DUTY_ONE + 8'(i * 4)))
          hrdata_ff[15:0] <= duty_buf_ff[i];
      end
    end
  end

  // Control register writes; unimplemented bits stay zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dead_cfg_ff    <= motor_pwm_pkg::RESET_ZERO;
      dead_sel_ff    <= motor_pwm_pkg::RESET_ZERO;
      fault_a_ctl_ff <= motor_pwm_pkg::RESET_ZERO;
      fault_b_ctl_ff <= motor_pwm_pkg::RESET_ZERO;
      override_ff    <= motor_pwm_pkg::RESET_OVERRIDE;
      update_ctl_ff  <= motor_pwm_pkg::RESET_ZERO;
    end else if (wr_pend_ff) begin
      if (reg_match(addr_ff, motor_pwm_pkg::ADDR_DEAD_TIME_CONFIG))
        dead_cfg_ff <= hwdata[15:0];
      if (reg_match(addr_ff, motor_pwm_pkg::ADDR_DEAD_TIME_SELECT))
        dead_sel_ff <= hwdata[15:0] & motor_pwm_pkg::MASK_DEAD_SELECT;
      if (reg_match(addr_ff, motor_pwm_pkg::ADDR_FAULT_A_CONTROL))
        fault_a_ctl_ff <= hwdata[15:0] & motor_pwm_pkg::MASK_FAULT_CTRL;
      if (reg_match(addr_ff, motor_pwm_pkg::ADDR_FAULT_B_CONTROL))
        fault_b_ctl_ff <= hwdata[15:0] & motor_pwm_pkg::MASK_FAULT_CTRL;
      if (reg_match(addr_ff, motor_pwm_pkg::ADDR_OVERRIDE_CONTROL))
        override_ff <= hwdata[15:0];
      if (reg_match(addr_ff, motor_pwm_pkg::ADDR_UPDATE_CONTROL))
        update_ctl_ff <= hwdata[15:0] & motor_pwm_pkg::MASK_UPDATE_CTRL;
    end
  end

  // Override in force: every cycle, or only at period start when synced
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      override_act_ff <= motor_pwm_pkg::RESET_OVERRIDE;
    end else if (!update_ctl_ff[motor_pwm_pkg::UPD_SYNC_BIT] || period_start) begin
      override_act_ff <= override_ff;
    end
  end

  // Duty buffers and active copies, one set per generator
  generate
    for (genvar g = 0; g < NP; g++) begin : g_duty
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          duty_buf_ff[g] <= motor_pwm_pkg::RESET_ZERO;
        end else if (wr_pend_ff &&
                     reg_match(addr_ff, motor_pwm_pkg::ADDR_DUTY_ONE + 8'(g * 4))) begin
          duty_buf_ff[g] <= hwdata[15:0];
        end
      end

      // Transfer is held off entirely while update disable is set
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          duty_act_ff[g] <= motor_pwm_pkg::RESET_ZERO;
        end else if (!update_ctl_ff[motor_pwm_pkg::UPD_DISABLE_BIT] &&
                     (update_ctl_ff[motor_pwm_pkg::UPD_IMMEDIATE_BIT] || period_start)) begin
          duty_act_ff[g] <= duty_buf_ff[g];
        end
      end

      // Comparator against the external time base count
      assign raw_pwm[g] = ({1'b0, time_base_count} < duty_act_ff[g]);
    end
  endgenerate

  // One prescale counter serves both units, so their ticks stay aligned
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale_cnt_ff <= 3'h0;
    end else begin
      prescale_cnt_ff <= prescale_cnt_ff + 3'h1;
    end
  end

  assign tick_a = prescale_tick(prescale_cnt_ff, dead_cfg.unit_a_prescale);
  assign tick_b = prescale_tick(prescale_cnt_ff, dead_cfg.unit_b_prescale);

  // Dead-time sequencers, one per pair
  generate
    for (genvar p = 0; p < NP; p++) begin : g_pair
      dead_time_pair u_dead_time (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .raw          (raw_pwm[p]),
        .independent  (update_ctl_ff[motor_pwm_pkg::UPD_MODE_LSB + p]),
        .tick_a       (tick_a),
        .tick_b       (tick_b),
        .count_a      (dead_cfg.unit_a_dead_count),
        .count_b      (dead_cfg.unit_b_dead_count),
        .sel_active   (dead_sel_ff[2 * p + 1]),
        .sel_inactive (dead_sel_ff[2 * p]),
        .drive_high   (gen_high[p]),
        .drive_low    (gen_low[p])
      );
    end
  endgenerate

  // Fault A: latch mode holds until a control write sees the input clear;
  // a fault arriving in that same cycle wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_a_latch_ff <= 1'b0;
    end else if (!fault_a_n && !fault_a_ctl.mode) begin
      fault_a_latch_ff <= 1'b1;
    end else if (wr_pend_ff && reg_match(addr_ff, motor_pwm_pkg::ADDR_FAULT_A_CONTROL)) begin
      fault_a_latch_ff <= 1'b0;
    end
  end

  // Fault A cycle by cycle: released at the period start after the input clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_a_cbc_ff <= 1'b0;
    end else if (!fault_a_n && fault_a_ctl.mode) begin
      fault_a_cbc_ff <= 1'b1;
    end else if (period_start) begin
      fault_a_cbc_ff <= 1'b0;
    end
  end

  // Fault B latch, same scheme as fault A
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_b_latch_ff <= 1'b0;
    end else if (!fault_b_n && !fault_b_ctl.mode) begin
      fault_b_latch_ff <= 1'b1;
    end else if (wr_pend_ff && reg_match(addr_ff, motor_pwm_pkg::ADDR_FAULT_B_CONTROL)) begin
      fault_b_latch_ff <= 1'b0;
    end
  end

  // Fault B cycle by cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_b_cbc_ff <= 1'b0;
    end else if (!fault_b_n && fault_b_ctl.mode) begin
      fault_b_cbc_ff <= 1'b1;
    end else if (period_start) begin
      fault_b_cbc_ff <= 1'b0;
    end
  end

  // A live fault input acts at once, without waiting for the flag flop
  assign fault_a_on = fault_a_latch_ff | fault_a_cbc_ff | ~fault_a_n;
  assign fault_b_on = fault_b_latch_ff | fault_b_cbc_ff | ~fault_b_n;

  // Pin selection: generator or manual value, then fault B, then fault A on top
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      nxt_high_pin[p] = override_act.generator_owns_pin[2 * p + 1] ? gen_high[p]
                                                                   : override_act.manual_pin_value[2 * p + 1];
      nxt_low_pin[p]  = override_act.generator_owns_pin[2 * p] ? gen_low[p]
                                                               : override_act.manual_pin_value[2 * p];
      if (fault_b_on && fault_b_ctl.pair_enable[p]) begin
        nxt_high_pin[p] = fault_b_ctl.override_value[2 * p + 1];
        nxt_low_pin[p]  = fault_b_ctl.override_value[2 * p];
      end
      if (fault_a_on && fault_a_ctl.pair_enable[p]) begin
        nxt_high_pin[p] = fault_a_ctl.override_value[2 * p + 1];
        nxt_low_pin[p]  = fault_a_ctl.override_value[2 * p];
      end
    end
  end

  // Pin flops; active level is high on every pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_high_ff <= 4'h0;
      pin_low_ff  <= 4'h0;
    end else begin
      pin_high_ff <= nxt_high_pin;
      pin_low_ff  <= nxt_low_pin;
    end
  end

  // Response is always OKAY
  assign hresp         = 1'b0;
  assign hrdata        = hrdata_ff;
  assign hreadyout     = hreadyout_ff;
  assign pair_high_pin = pin_high_ff;
  assign pair_low_pin  = pin_low_ff;

endmodule : motor_pwm_output_stage

// [verilog/motor_pwm_pkg.sv]
// Shared constants and types for the motor PWM output stage
package motor_pwm_pkg;

  // Register byte offsets on the bus, one aligned word each
  localparam logic [7:0] ADDR_DEAD_TIME_CONFIG  = 8'h00;
  localparam logic [7:0] ADDR_DEAD_TIME_SELECT  = 8'h04;
  localparam logic [7:0] ADDR_FAULT_A_CONTROL   = 8'h08;
  localparam logic [7:0] ADDR_FAULT_B_CONTROL   = 8'h0c;
  localparam logic [7:0] ADDR_OVERRIDE_CONTROL  = 8'h10;
  localparam logic [7:0] ADDR_DUTY_ONE          = 8'h14;
  localparam logic [7:0] ADDR_DUTY_STRIDE       = 8'h04;
  localparam logic [7:0] ADDR_UPDATE_CONTROL    = 8'h24;
  localparam logic [7:0] ADDR_FAULT_STATUS      = 8'h28;

  // Reset values
  localparam logic [15:0] RESET_ZERO     = 16'h0000;
  localparam logic [15:0] RESET_OVERRIDE = 16'hff00;

  // Update control register fields
  localparam int UPD_DISABLE_BIT   = 0;
  localparam int UPD_SYNC_BIT      = 1;
  localparam int UPD_IMMEDIATE_BIT = 2;
  localparam int UPD_MODE_LSB      = 8;

  // Writable bit masks
  localparam logic [15:0] MASK_DEAD_SELECT = 16'h00ff;
  localparam logic [15:0] MASK_FAULT_CTRL  = 16'hff8f;
  localparam logic [15:0] MASK_UPDATE_CTRL = 16'h0f07;

  // Fault status register fields
  localparam int STAT_FAULT_A_BIT = 0;
  localparam int STAT_FAULT_B_BIT = 1;

  // Pair count and prescale counter width
  localparam int PAIRS         = 4;
  localparam int PRESCALE_BITS = 3;

  // Dead-time configuration word
  typedef struct packed {
    logic [1:0] unit_b_prescale;
    logic [5:0] unit_b_dead_count;
    logic [1:0] unit_a_prescale;
    logic [5:0] unit_a_dead_count;
  } dead_cfg_type;

  // Fault control word
  typedef struct packed {
    logic [7:0] override_value;
    logic       mode;
    logic [2:0] unused;
    logic [3:0] pair_enable;
  } fault_ctl_type;

  // Output override word
  typedef struct packed {
    logic [7:0] generator_owns_pin;
    logic [7:0] manual_pin_value;
  } override_ctl_type;

  // Dead-time sequencer states
  typedef enum logic [1:0] {
    DT_LOW_ON   = 2'b00,
    DT_WAIT_HI  = 2'b01,
    DT_HIGH_ON  = 2'b10,
    DT_WAIT_LO  = 2'b11
  } dt_state_type;

endpackage : motor_pwm_pkg

// [verilog/dead_time_pair.sv]
// Dead-time sequencer for one high/low output pair
`timescale 1ns/1ps
module dead_time_pair (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       raw,
  input  wire logic       independent,
  input  wire logic       tick_a,
  input  wire logic       tick_b,
  input  wire logic [5:0] count_a,
  input  wire logic [5:0] count_b,
  input  wire logic       sel_active,
  input  wire logic       sel_inactive,
  output logic            drive_high,
  output logic            drive_low
);

  motor_pwm_pkg::dt_state_type state_ff;  // Sequencer state
  logic [5:0]                  remain_ff; // Dead ticks still to wait
  logic                        unit_ff;   // Unit timing this wait, 1 = unit B
  logic                        tick_sel;  // Tick of the unit in use

  assign tick_sel = unit_ff ? tick_b : tick_a;

  // Sequencer: both pins stay inactive while a wait runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff  <= motor_pwm_pkg::DT_WAIT_LO;
      remain_ff <= 6'h00;
      unit_ff   <= 1'b0;
    end else begin
      case (state_ff)
        motor_pwm_pkg::DT_LOW_ON: begin
          // Rising raw: low drops now, high waits the active-edge dead time
          if (raw) begin
            state_ff  <= motor_pwm_pkg::DT_WAIT_HI;
            remain_ff <= sel_active ? count_b : count_a;
            unit_ff   <= sel_active;
          end
        end
        motor_pwm_pkg::DT_WAIT_HI: begin
          // High never drove, so an early fall returns straight to low
          if (!raw) begin
            state_ff <= motor_pwm_pkg::DT_LOW_ON;
          end else if (remain_ff == 6'h00) begin
            state_ff <= motor_pwm_pkg::DT_HIGH_ON;
          end else if (tick_sel) begin
            remain_ff <= remain_ff - 6'h01;
          end
        end
        motor_pwm_pkg::DT_HIGH_ON: begin
          // Falling raw: high drops now, low waits the inactive-edge dead time
          if (!raw) begin
            state_ff  <= motor_pwm_pkg::DT_WAIT_LO;
            remain_ff <= sel_inactive ? count_b : count_a;
            unit_ff   <= sel_inactive;
          end
        end
        motor_pwm_pkg::DT_WAIT_LO: begin
          if (raw) begin
            state_ff <= motor_pwm_pkg::DT_HIGH_ON;
          end else if (remain_ff == 6'h00) begin
            state_ff <= motor_pwm_pkg::DT_LOW_ON;
          end else if (tick_sel) begin
            remain_ff <= remain_ff - 6'h01;
          end
        end
        default: begin
          state_ff <= motor_pwm_pkg::DT_WAIT_LO;
        end
      endcase
    end
  end

  // Independent pairs bypass the sequencer and follow raw on both pins
  always_comb begin
    if (independent) begin
      drive_high = raw;
      drive_low  = raw;
    end else begin
      drive_high = (state_ff == motor_pwm_pkg::DT_HIGH_ON);
      drive_low  = (state_ff == motor_pwm_pkg::DT_LOW_ON);
    end
  end

endmodule : dead_time_pair

// [sim/motor_pwm_output_stage_asserts.sv]
// Port-level checker for the motor PWM output stage
`timescale 1ns/1ps
module motor_pwm_asserts (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [14:0] time_base_count,
  input wire logic        period_start,
  input wire logic        fault_a_n,
  input wire logic        fault_b_n,
  input wire logic [3:0]  pair_high_pin,
  input wire logic [3:0]  pair_low_pin
);
  logic        wr_ph_ff;                            // Write data phase pending
  logic [7:0]  wa_ff;                               // Its byte address
  logic [15:0] fa_ff, fb_ff, ov_ff, up_ff, dt_ff, ds_ff, oa_ff; // Shadow control words, override in force
  logic [7:0]  dead_ff;                             // Cycles with both pair 1 pins off
  logic        rd_go, wr_go, ok;                    // Transfer starts, plain complementary pair 1
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  assign wr_go = hsel && hready && htrans[1] && hwrite;
  assign ok = (oa_ff[9:8] == 2'b11) && !fa_ff[0] && !fb_ff[0] && !up_ff[8];
  // Shadow follows completed writes, so every check sees the live settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr_ph_ff, wa_ff, fa_ff, fb_ff, up_ff, dt_ff, ds_ff} <= '0;
      ov_ff <= 16'hff00;
      oa_ff <= 16'hff00;
    end else begin
      // A synced override only reaches the pins at a period start
      if (!up_ff[1] || period_start) oa_ff <= ov_ff;
      if (hready) wr_ph_ff <= wr_go;
      if (hready) wa_ff <= haddr[7:0];
      if (wr_ph_ff && hready) begin
        case (wa_ff)
          8'h00: dt_ff <= hwdata[15:0];
          8'h04: ds_ff <= hwdata[15:0];
          8'h08: fa_ff <= hwdata[15:0];
          8'h0c: fb_ff <= hwdata[15:0];
          8'h10: ov_ff <= hwdata[15:0];
          8'h24: up_ff <= hwdata[15:0];
          default: ;
        endcase
      end
    end
  end
  // Dead gap counter; saturates so a long idle never wraps to a small value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) dead_ff <= 8'h00;
    else if (pair_high_pin[0] || pair_low_pin[0]) dead_ff <= 8'h00;
    else if (dead_ff != 8'hff) dead_ff <= dead_ff + 8'h01;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rwait; !hreadyout ##1 hreadyout; endsequence
  property p_rd; rd_go |=> s_rwait; endproperty
  a_rd: assert property (p_rd) else $error("read wait not one cycle");
  property p_wr; wr_go |=> hreadyout; endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
  property p_top; hreadyout |-> hrdata[31:16] == 16'h0000; endproperty
  a_top: assert property (p_top) else $error("upper read half set");
  property p_fa; !fault_a_n && fa_ff[0] |=> {pair_high_pin[0], pair_low_pin[0]} == $past(fa_ff[9:8]); endproperty
  a_fa: assert property (p_fa) else $error("fault one value not forced");
  property p_fb; !fault_b_n && fb_ff[0] && !fa_ff[0] |=> {pair_high_pin[0], pair_low_pin[0]} == $past(fb_ff[9:8]);
  endproperty
  a_fb: assert property (p_fb) else $error("fault two value not forced");
  property p_ovr; ov_ff[9:8] == 2'b00 && $stable(ov_ff) && $stable(up_ff) && !up_ff[1] && !fa_ff[0] && !fb_ff[0]
    |=> {pair_high_pin[0], pair_low_pin[0]} == $past(ov_ff[1:0]); endproperty
  a_ovr: assert property (p_ovr) else $error("manual value not driven");
  property p_dead; ok && $past(ok) |-> !(pair_high_pin[0] && pair_low_pin[0]); endproperty
  a_dead: assert property (p_dead) else $error("pair both on");
  property p_gap; ok && dt_ff[7:6] == 2'b00 && !ds_ff[1] && $rose(pair_high_pin[0])
    |-> {1'b0, dead_ff} + 9'h001 >= {3'b000, dt_ff[5:0]}; endproperty
  a_gap: assert property (p_gap) else $error("dead gap too short");
endmodule : motor_pwm_asserts
bind motor_pwm_output_stage motor_pwm_asserts chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .time_base_count, .period_start, .fault_a_n, .fault_b_n,
  .pair_high_pin, .pair_low_pin);

// [sim/gate_driver_model.sv]
// Gate driver model for pair 1: measures the off gap before each high turn-on
`timescale 1ns/1ps
module gate_driver_model (
  input  wire logic hclk,
  input  wire logic high,
  input  wire logic low,
  output int        gap
);
  int   run = 0;        // Cycles with both gates off so far
  logic high_q = 1'b0;  // High gate one cycle ago
  // Sampled on the falling edge, where the registered pins are settled
  always @(negedge hclk) begin
    high_q <= high;
    run <= (high || low) ? 0 : run + 1;
    if (high && !high_q) gap <= run;
  end
endmodule : gate_driver_model

// [sim/motor_pwm_output_stage_tb_top.sv]
// Self-checking bench for the motor PWM output stage
`timescale 1ns/1ps
module motor_pwm_output_stage_tb_top;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0; // Clock, reset, bus controls
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;   // Bus address and data
  logic [1:0]  htrans = 2'b00;                                          // Transfer kind
  logic [2:0]  hsize = 3'b010;                                          // Always whole words
  logic        hreadyout, hresp, period_start = 1'b0;                   // Bus answer, period marker
  logic        fault_a_n = 1'b1, fault_b_n = 1'b1;                      // Fault inputs, idle high
  logic [14:0] tbc = 15'h0020;                                          // Time base count
  logic [3:0]  pair_high_pin, pair_low_pin;                             // Gate outputs
  logic [15:0] tm [12] = '{16'hffff, 16'h00ff, 16'hff8f, 16'hff8f, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
                           16'hffff, 16'h0f07, 16'h0000, 16'h0000};    // Writable bits per address
  int          gap, pp, nn, num_errors = 0, n_compared = 0;
  always #12.5 hclk = ~hclk;
  motor_pwm_output_stage dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .time_base_count(tbc), .period_start, .fault_a_n,
    .fault_b_n, .pair_high_pin, .pair_low_pin);
  gate_driver_model drv (.hclk, .high(pair_high_pin[0]), .low(pair_low_pin[0]), .gap);
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // One single transfer; ready is read at the falling edge, so it matches what the rising edge samples
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    logic r;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do begin @(negedge hclk); r = hreadyout; @(posedge hclk); end while (r !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(negedge hclk); r = hreadyout; q = hrdata; @(posedge hclk); end while (r !== 1'b1);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    cmp(q, e);
    cmp({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask : chk
  task automatic wait_c(input int n);
    repeat (n) @(posedge hclk);
  endtask : wait_c
  // Pins as {high[3:0], low[3:0]}, looked at mid-cycle
  task automatic pins(input logic [7:0] e);
    @(negedge hclk);
    cmp({24'h00_0000, pair_high_pin, pair_low_pin}, {24'h00_0000, e});
    @(posedge hclk);
  endtask : pins
  task automatic pulse;
    period_start <= 1'b1;
    @(posedge hclk);
    period_start <= 1'b0;
    wait_c(2);
  endtask : pulse
  task automatic finish_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // Watchdog: the whole sequence needs under 3000 cycles
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
  initial begin
    wait_c(4);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset value, writable mask, then reset value restored, for every register and one unmapped place
    for (int i = 0; i < 12; i++) begin
      chk(8'(4 * i), {16'h0000, (i == 4) ? 16'hff00 : 16'h0000});
      wr(8'(4 * i), 32'hffff_ffff);
      chk(8'(4 * i), {16'h0000, tm[i]});
      wr(8'(4 * i), {16'h0000, (i == 4) ? 16'hff00 : 16'h0000});
    end
    wr(8'h24, 32'h0000_0004);
    wr(8'h14, 32'h0000_0010);
    // Four prescales of unit A, then unit B chosen for the active edge
    for (int p = 0; p < 5; p++) begin
      wr(8'h00, (p < 4) ? {16'h0000, 2'(p), 6'h05, 8'h00} >> 8 : 32'h0000_8703);
      if (p == 4) wr(8'h04, 32'h0000_0002);
      tbc <= 15'h0020;
      wait_c(60);
      tbc <= 15'h0000;
      wait_c(80);
      pp = (p < 4) ? (1 << p) : 4;
      nn = (p < 4) ? 5 * pp : 28;
      cmp(32'(gap >= nn - pp && gap <= nn + 3), 32'h0000_0001);
    end
    tbc <= 15'h0020;
    wr(8'h08, 32'h0000_0201);
    wr(8'h0c, 32'h0000_0103);
    wait_c(60);
    fault_a_n <= 1'b0;
    fault_b_n <= 1'b0;
    wait_c(3);
    fault_a_n <= 1'b1;
    fault_b_n <= 1'b1;
    wait_c(3);
    pins(8'h1c);
    chk(8'h28, 32'h0000_0003);
    wr(8'h08, 32'h0000_0000);
    wr(8'h0c, 32'h0000_0281);
    wait_c(60);
    pins(8'h0f);
    fault_b_n <= 1'b0;
    wait_c(3);
    fault_b_n <= 1'b1;
    wait_c(3);
    pins(8'h1e);
    pulse();
    wait_c(60);
    pins(8'h0f);
    wr(8'h0c, 32'h0000_0000);
    wr(8'h10, 32'h0000_fc02);
    wait_c(3);
    pins(8'h1e);
    wr(8'h24, 32'h0000_0006);
    wr(8'h10, 32'h0000_fc03);
    wait_c(4);
    pins(8'h1e);
    pulse();
    pins(8'h1f);
    wr(8'h10, 32'h0000_ff00);
    pulse();
    wr(8'h24, 32'h0000_0001);
    wr(8'h14, 32'h0000_0030);
    pulse();
    wait_c(60);
    pins(8'h0f);
    wr(8'h24, 32'h0000_0000);
    wait_c(20);
    pins(8'h0f);
    pulse();
    wait_c(60);
    pins(8'h1e);
    wr(8'h24, 32'h0000_0100);
    wait_c(4);
    pins(8'h1f);
    finish_test();
  end
endmodule : motor_pwm_output_stage_tb_top
